// File: core/rsv_params.svh
// Constants of the regulator serial voltage-code register bank
// Operation
// - Current reading, full scale means platform maximum
// - Voltage reading is sense difference, 8 mV
// - Temperature reading in whole degrees Celsius
// - Power reading is voltage times current
// - Input voltage reading, 112 mV per count
// - Reading secondary status copies it to last-read
// - Current limit captured once, then read-only
// - Writable temperature limit drives hot alarm
// - Fast slew rate is fixed, read-only
// - Slow slew rate is fast divided
// - Divider selector is one-hot, default divide-by-four
// - Hold boot voltage until first set command
// - Deepest sleep exit latency reads 8Ch
// - Light load exit latency reads 55h
// - Enable-to-ready latency encoded mantissa/exponent, CAh
// - Code above ceiling answered not supported
// - Programmed voltage code register resets zero
// - Programmed power state readable and writable
// - Signed margin offset added to voltage code
// - Config bit 0 makes zero code valid once the code has been nonzero since reset
// - Config bit 1 locks code until state zero
// - Temperature zone is thermometer, 3 degree steps
// - Three-wire bus: clock, data, open-drain alert
`ifndef RSV_PARAMS_SVH
`define RSV_PARAMS_SVH
// ==========================================================
// Register offsets
`define RSV_A_STATUS 8'h11
`define RSV_A_ZONE 8'h12
`define RSV_A_CURRENT 8'h15
`define RSV_A_VOLT 8'h16
`define RSV_A_TEMP 8'h17
`define RSV_A_POWER 8'h18
`define RSV_A_VIN 8'h1a
`define RSV_A_LAST 8'h1c
`define RSV_A_ICCMAX 8'h21
`define RSV_A_TMAX 8'h22
`define RSV_A_FAST 8'h24
`define RSV_A_SLOW 8'h25
`define RSV_A_BOOT 8'h26
`define RSV_A_SEL 8'h2a
`define RSV_A_DEEP 8'h2b
`define RSV_A_LIGHT 8'h2c
`define RSV_A_ENRDY 8'h2d
`define RSV_A_CEIL 8'h30
`define RSV_A_VID 8'h31
`define RSV_A_PS 8'h32
`define RSV_A_OFS 8'h33
`define RSV_A_CFG 8'h34
// ==========================================================
// Reset values and constants
`define RSV_R_TELEM 8'h01
`define RSV_R_TMAX 8'h64
`define RSV_FAST_STD 8'h32
`define RSV_FAST_SLOW_VARIANT 8'h0a
`define RSV_R_SEL 4'h2
`define RSV_R_CEIL 8'hb5
`define RSV_DEEP_LAT 8'h8c
`define RSV_LIGHT_LAT 8'h55
`define RSV_ENRDY_LAT 8'hca
`define RSV_ZONE_STEP 9'h003
`define RSV_CFG_ZERO_VALID 0
`define RSV_CFG_LOCK 1
`define RSV_CAP_DELAY 2'h2
// ==========================================================
// Answer codes
`define RSV_RESP_ACK 8'h00
`define RSV_RESP_NOT_SUPPORTED 8'h01
`define RSV_RESP_REJECT 8'h02
`endif

// File: core/rsv_pkg.sv
// Types of the regulator serial voltage-code register bank
package rsv_pkg;
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] data;
    } rsv_req_t;

    typedef struct packed {
        logic [7:0] current;
        logic [7:0] sense_pos;
        logic [7:0] sense_neg;
        logic [7:0] temp;
        logic [7:0] vin;
        logic [7:0] status;
        logic [7:0] cur_limit;
        logic [7:0] boot;
    } rsv_telem_t;

    typedef enum logic [2:0] {
        RSV_L_IDLE = 3'b000,
        RSV_L_OP = 3'b001,
        RSV_L_ADDR = 3'b010,
        RSV_L_DATA = 3'b011,
        RSV_L_WAIT = 3'b100,
        RSV_L_RESP = 3'b101
    } rsv_lstate_t;
endpackage : rsv_pkg

// File: core/rsv_regs.sv
// Register bank with serial link front end
`timescale 1ns/1ps
`include "rsv_params.svh"
module rsv_regs #(
    parameter bit SLOW_VARIANT = 1'b0
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_link_clk,
    input wire logic i_sdio_in,
    output logic o_sdio_out,
    output logic o_sdio_oe,
    output logic o_alert_out,
    output logic o_alert_oe,
    input rsv_pkg::rsv_telem_t i_telem,
    output logic o_hot_alarm_output,
    output logic o_regulator_ready_output,
    output logic [7:0] o_voltage_target
);
    import rsv_pkg::*;

    // ==========================================================
    // Link domain: frame receive and answer
    logic lrst1_reg, lrst_n_reg;
    rsv_lstate_t lstate_reg;
    logic [2:0] lcnt_reg;
    rsv_req_t lreq_reg;
    logic req_tgl_reg, ack_tgl_reg;
    logic ack1_reg, ack2_reg, ack_seen_reg;
    logic [7:0] lshift_reg, resp_reg;
    logic sdio_out_reg, sdio_oe_reg;

    always_ff @(posedge i_link_clk) begin
        lrst1_reg <= i_rst_n;
        lrst_n_reg <= lrst1_reg;
        ack1_reg <= ack_tgl_reg;
        ack2_reg <= ack1_reg;
    end

    // Serial frame on the master clock: start 0, op, address, data on writes
    always_ff @(posedge i_link_clk) begin
        if (!lrst_n_reg) begin
            lstate_reg <= RSV_L_IDLE;
            lcnt_reg <= 3'h0;
            lreq_reg <= '0;
            req_tgl_reg <= 1'b0;
            ack_seen_reg <= 1'b0;
            lshift_reg <= 8'h00;
            sdio_out_reg <= 1'b1;
            sdio_oe_reg <= 1'b0;
        end else begin
            unique case (lstate_reg)
                RSV_L_IDLE: begin
                    sdio_oe_reg <= 1'b0;
                    if (!i_sdio_in && !sdio_oe_reg) begin // Own last answer bit may still be on the wire
                        lstate_reg <= RSV_L_OP;
                    end
                end
                RSV_L_OP: begin
                    lreq_reg.wr <= i_sdio_in;
                    lcnt_reg <= 3'h7;
                    lstate_reg <= RSV_L_ADDR;
                end
                RSV_L_ADDR: begin
                    lreq_reg.addr <= {lreq_reg.addr[6:0], i_sdio_in};
                    lcnt_reg <= lcnt_reg - 3'h1;
                    if (lcnt_reg == 3'h0) begin
                        if (lreq_reg.wr) begin
                            lcnt_reg <= 3'h7;
                            lstate_reg <= RSV_L_DATA;
                        end else begin
                            req_tgl_reg <= ~req_tgl_reg;
                            lstate_reg <= RSV_L_WAIT;
                        end
                    end
                end
                RSV_L_DATA: begin
                    lreq_reg.data <= {lreq_reg.data[6:0], i_sdio_in};
                    lcnt_reg <= lcnt_reg - 3'h1;
                    if (lcnt_reg == 3'h0) begin
                        req_tgl_reg <= ~req_tgl_reg;
                        lstate_reg <= RSV_L_WAIT;
                    end
                end
                RSV_L_WAIT: begin
                    // Core holds the answer word still until the next request
                    if (ack2_reg != ack_seen_reg) begin
                        ack_seen_reg <= ack2_reg;
                        lshift_reg <= resp_reg;
                        sdio_out_reg <= 1'b0;
                        sdio_oe_reg <= 1'b1;
                        lcnt_reg <= 3'h7;
                        lstate_reg <= RSV_L_RESP;
                    end
                end
                RSV_L_RESP: begin
                    sdio_out_reg <= lshift_reg[7];
                    lshift_reg <= {lshift_reg[6:0], 1'b0};
                    lcnt_reg <= lcnt_reg - 3'h1;
                    if (lcnt_reg == 3'h0) begin
                        lstate_reg <= RSV_L_IDLE;
                    end
                end
                default: begin
                    lstate_reg <= RSV_L_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Core domain: request crossing and pin synchronisers
    logic req1_reg, req2_reg, req3_reg, req_pulse;
    rsv_telem_t t1_reg, t2_reg;

    always_ff @(posedge i_clk) begin
        req1_reg <= req_tgl_reg;
        req2_reg <= req1_reg;
        req3_reg <= req2_reg;
        t1_reg <= i_telem;
        t2_reg <= t1_reg;
    end

    assign req_pulse = req2_reg ^ req3_reg;

    // ==========================================================
    // Power-up captures
    logic [1:0] cap_cnt_reg;
    logic cap_done_reg;
    logic [7:0] icc_reg, boot_reg;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cap_cnt_reg <= 2'h0;
            cap_done_reg <= 1'b0;
            icc_reg <= 8'h00;
            boot_reg <= 8'h00;
        end else if (!cap_done_reg) begin
            cap_cnt_reg <= cap_cnt_reg + 2'h1;
            if (cap_cnt_reg == `RSV_CAP_DELAY) begin
                cap_done_reg <= 1'b1;
                icc_reg <= t2_reg.cur_limit;
                boot_reg <= t2_reg.boot;
            end
        end
    end

    // ==========================================================
    // Telemetry
    logic [7:0] cur_reg, volt_reg, temp_reg, pwr_reg, vin_reg, stat_reg, zone_reg;
    logic [15:0] vi_prod;
    logic [7:0] zone_next, tmax_reg;

    assign vi_prod = volt_reg * cur_reg;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cur_reg <= `RSV_R_TELEM;
            volt_reg <= `RSV_R_TELEM;
            temp_reg <= `RSV_R_TELEM;
            pwr_reg <= `RSV_R_TELEM;
            vin_reg <= 8'h00;
            stat_reg <= 8'h00;
            zone_reg <= 8'h00;
        end else begin
            cur_reg <= t2_reg.current;
            // Negative difference means no output; clamp instead of wrapping
            volt_reg <= (t2_reg.sense_pos > t2_reg.sense_neg) ?
                        (t2_reg.sense_pos - t2_reg.sense_neg) : 8'h00;
            temp_reg <= t2_reg.temp;
            pwr_reg <= vi_prod[15:8];
            vin_reg <= t2_reg.vin;
            stat_reg <= t2_reg.status;
            zone_reg <= zone_next;
        end
    end

    // Top zone bit marks the limit, each lower bit one step below it
    genvar gk;
    generate
        for (gk = 0; gk < 8; gk++) begin : g_zone
            localparam logic [8:0] ZOFS = 9'(7 - gk) * `RSV_ZONE_STEP;
            assign zone_next[gk] = ({1'b0, temp_reg} + ZOFS) >= {1'b0, tmax_reg};
        end
    endgenerate

    // ==========================================================
    // Host-written registers and answers
    rsv_req_t creq;
    logic [7:0] last_reg, ofs_reg, cfg_reg, vid_reg, ps_reg, ceil_reg;
    logic [3:0] sel_reg;
    logic lock_reg, set_seen_reg;
    logic [7:0] fast_rate, slow_rate, rdata;

    assign creq = lreq_reg;
    assign fast_rate = SLOW_VARIANT ? `RSV_FAST_SLOW_VARIANT : `RSV_FAST_STD;

    always_comb begin
        unique case (sel_reg)
            4'h1: slow_rate = {1'b0, fast_rate[7:1]};
            4'h2: slow_rate = {2'b00, fast_rate[7:2]};
            4'h4: slow_rate = {3'b000, fast_rate[7:3]};
            4'h8: slow_rate = {4'h0, fast_rate[7:4]};
            default: slow_rate = fast_rate;
        endcase
    end

    always_comb begin
        unique case (creq.addr)
            `RSV_A_STATUS: rdata = stat_reg;
            `RSV_A_ZONE: rdata = zone_reg;
            `RSV_A_CURRENT: rdata = cur_reg;
            `RSV_A_VOLT: rdata = volt_reg;
            `RSV_A_TEMP: rdata = temp_reg;
            `RSV_A_POWER: rdata = pwr_reg;
            `RSV_A_VIN: rdata = vin_reg;
            `RSV_A_LAST: rdata = last_reg;
            `RSV_A_ICCMAX: rdata = icc_reg;
            `RSV_A_TMAX: rdata = tmax_reg;
            `RSV_A_FAST: rdata = fast_rate;
            `RSV_A_SLOW: rdata = slow_rate;
            `RSV_A_BOOT: rdata = boot_reg;
            `RSV_A_SEL: rdata = {4'h0, sel_reg};
            `RSV_A_DEEP: rdata = `RSV_DEEP_LAT;
            `RSV_A_LIGHT: rdata = `RSV_LIGHT_LAT;
            `RSV_A_ENRDY: rdata = `RSV_ENRDY_LAT;
            `RSV_A_CEIL: rdata = ceil_reg;
            `RSV_A_VID: rdata = vid_reg;
            `RSV_A_PS: rdata = ps_reg;
            `RSV_A_OFS: rdata = ofs_reg;
            `RSV_A_CFG: rdata = cfg_reg;
            default: rdata = 8'h00;
        endcase
    end

    // Unlisted writes, including read-only registers, only get an ACK
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            tmax_reg <= `RSV_R_TMAX;
            sel_reg <= `RSV_R_SEL;
            ceil_reg <= `RSV_R_CEIL;
            vid_reg <= 8'h00;
            ps_reg <= 8'h00;
            ofs_reg <= 8'h00;
            cfg_reg <= 8'h00;
            lock_reg <= 1'b0;
            set_seen_reg <= 1'b0;
            last_reg <= 8'h00;
            resp_reg <= 8'h00;
            ack_tgl_reg <= 1'b0;
        end else if (req_pulse) begin
            ack_tgl_reg <= ~ack_tgl_reg;
            resp_reg <= `RSV_RESP_ACK;
            if (!creq.wr) begin
                resp_reg <= rdata;
                if (creq.addr == `RSV_A_STATUS) begin
                    last_reg <= stat_reg;
                end
            end else begin
                unique case (creq.addr)
                    `RSV_A_TMAX: tmax_reg <= creq.data;
                    `RSV_A_SEL: begin
                        if ($onehot(creq.data[3:0]) && creq.data[7:4] == 4'h0) begin
                            sel_reg <= creq.data[3:0];
                        end else begin
                            resp_reg <= `RSV_RESP_REJECT;
                        end
                    end
                    `RSV_A_CEIL: ceil_reg <= creq.data;
                    `RSV_A_VID: begin
                        if (creq.data > ceil_reg) begin
                            resp_reg <= `RSV_RESP_NOT_SUPPORTED;
                        end else if (lock_reg) begin
                            resp_reg <= `RSV_RESP_REJECT;
                        end else begin
                            vid_reg <= creq.data;
                            set_seen_reg <= 1'b1;
                        end
                    end
                    `RSV_A_PS: begin
                        if (creq.data == 8'h00) begin
                            ps_reg <= creq.data;
                            lock_reg <= 1'b0;
                        end else if (lock_reg) begin
                            resp_reg <= `RSV_RESP_REJECT;
                        end else begin
                            ps_reg <= creq.data;
                        end
                    end
                    `RSV_A_OFS: ofs_reg <= creq.data;
                    `RSV_A_CFG: begin
                        cfg_reg <= creq.data;
                        if (creq.data[`RSV_CFG_LOCK]) begin
                            lock_reg <= 1'b1;
                        end
                    end
                    default: resp_reg <= `RSV_RESP_ACK;
                endcase
            end
        end
    end

    // ==========================================================
    // Regulator outputs
    logic [8:0] margin_sum;
    logic [7:0] code_eff, target_reg;
    logic hot_reg, ready_reg, nonzero_reg, alert_oe_reg, alert_out_reg;

    assign margin_sum = {1'b0, vid_reg} + {ofs_reg[7], ofs_reg};
    always_comb begin
        if (!set_seen_reg) begin
            code_eff = boot_reg;
        end else if (ofs_reg[7] && margin_sum[8]) begin // Bit 8 set: margin went below zero
            code_eff = 8'h00;
        end else if (!ofs_reg[7] && margin_sum[8]) begin
            code_eff = 8'hff;
        end else begin
            code_eff = margin_sum[7:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            hot_reg <= 1'b0;
            ready_reg <= 1'b0;
            nonzero_reg <= 1'b0;
            target_reg <= 8'h00;
            alert_oe_reg <= 1'b0;
            alert_out_reg <= 1'b0;
        end else begin
            hot_reg <= temp_reg >= tmax_reg;
            target_reg <= code_eff;
            if (code_eff != 8'h00 && cap_done_reg) begin
                nonzero_reg <= 1'b1;
            end
            // Zero code disables unless config says it is a real setting and the code has been nonzero before
            ready_reg <= cap_done_reg && (code_eff != 8'h00 ||
                         (cfg_reg[`RSV_CFG_ZERO_VALID] && nonzero_reg));
            alert_oe_reg <= stat_reg != last_reg;
            alert_out_reg <= 1'b0;
        end
    end

    assign o_sdio_out = sdio_out_reg;
    assign o_sdio_oe = sdio_oe_reg;
    assign o_alert_out = alert_out_reg;
    assign o_alert_oe = alert_oe_reg;
    assign o_hot_alarm_output = hot_reg;
    assign o_regulator_ready_output = ready_reg;
    assign o_voltage_target = target_reg;

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    property p_last_read;
        req_pulse && !creq.wr && creq.addr == `RSV_A_STATUS |=> last_reg == $past(stat_reg);
    endproperty
    a_last_read: assert property (p_last_read) else $error("last-read copy wrong");
    property p_ceiling;
        req_pulse && creq.wr && creq.addr == `RSV_A_VID && creq.data > ceil_reg
            |=> $stable(vid_reg) && resp_reg == `RSV_RESP_NOT_SUPPORTED;
    endproperty
    a_ceiling: assert property (p_ceiling) else $error("code above ceiling taken");
    property p_icc_fixed;
        cap_done_reg |=> $stable(icc_reg) && $stable(boot_reg);
    endproperty
    a_icc_fixed: assert property (p_icc_fixed) else $error("captured value changed");
    property p_slow_rate;
        sel_reg == 4'h2 |-> slow_rate == {2'b00, fast_rate[7:2]};
    endproperty
    a_slow_rate: assert property (p_slow_rate) else $error("slow rate mismatch");
    property p_sel_onehot;
        $onehot(sel_reg);
    endproperty
    a_sel_onehot: assert property (p_sel_onehot) else $error("selector not one-hot");
    property p_lock;
        lock_reg && req_pulse && creq.wr && creq.addr == `RSV_A_VID |=> $stable(vid_reg);
    endproperty
    a_lock: assert property (p_lock) else $error("locked code changed");
    property p_hot;
        temp_reg >= tmax_reg ##1 $stable(tmax_reg) |-> hot_reg;
    endproperty
    a_hot: assert property (p_hot) else $error("hot alarm missing");
    property p_power;
        ##2 1 |-> pwr_reg == $past(vi_prod[15:8]);
    endproperty
    a_power: assert property (p_power) else $error("power reading wrong");
    property p_ready_zero;
        code_eff == 8'h00 && !cfg_reg[`RSV_CFG_ZERO_VALID] |=> !ready_reg;
    endproperty
    a_ready_zero: assert property (p_ready_zero) else $error("ready on zero code");
    c_read_status: cover property (req_pulse && !creq.wr && creq.addr == `RSV_A_STATUS);
    c_set_code: cover property (req_pulse && creq.wr && creq.addr == `RSV_A_VID ##1 set_seen_reg);
    c_unlock: cover property (lock_reg ##[1:200] !lock_reg);
endmodule : rsv_regs

// File: verif/rsv_master.sv
// Serial bus master model that clocks frames into the register bank
`timescale 1ns/1ps
module rsv_master (
    output logic o_link_clk,
    output logic o_sdio_drv,
    output logic o_sdio_oe,
    input wire logic i_sdio_out,
    input wire logic i_sdio_oe
);
    logic run = 1'b1;
    // Clock stands low between frames; it only stops once low
    initial begin
        o_link_clk = 1'b0;
        o_sdio_drv = 1'b1;
        o_sdio_oe = 1'b0;
        #7;
        forever begin
            #24;
            if (run || o_link_clk) begin
                o_link_clk = ~o_link_clk;
            end
        end
    end
    // Bits change after the falling edge, the device samples on the rising one
    task frame(input logic wr, input logic [7:0] addr, input logic [7:0] data, output logic [7:0] ans);
        logic [16:0] bits;
        logic seen;
        int w;
        bits = {wr, addr, data};
        run = 1'b1;
        @(negedge o_link_clk);
        o_sdio_oe = 1'b1;
        o_sdio_drv = 1'b0;
        for (int i = 0; i < (wr ? 17 : 9); i++) begin
            @(negedge o_link_clk);
            o_sdio_drv = bits[16 - i];
        end
        @(negedge o_link_clk);
        o_sdio_oe = 1'b0;
        o_sdio_drv = 1'b1;
        seen = 1'b0;
        w = 0;
        while (!seen && w < 100) begin
            @(negedge o_link_clk);
            w++;
            seen = (i_sdio_oe === 1'b1) && (i_sdio_out === 1'b0);
        end
        for (int i = 0; i < 8; i++) begin
            @(negedge o_link_clk);
            ans = {ans[6:0], i_sdio_out};
        end
        if (!seen) begin
            ans = 8'hxx;
        end
        repeat (3) @(negedge o_link_clk);
        run = 1'b0;
    endtask : frame
endmodule : rsv_master

// File: verif/test_rsv_regs.sv
// Self-checking bench of the register bank with a reference model
`timescale 1ns/1ps
module test_rsv_regs;
    import rsv_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic lclk, mdrv, moe, dout, doe, aoe, aout, hot, rdy, wire_d;
    logic [7:0] tgt, ans, lim0, boot0;
    rsv_telem_t tel;
    int errors = 0;
    int num_checks = 0;
    int seed = 76267;
    int lock = 0;
    int started = 0;
    logic [7:0] mdl [256] = '{default: 8'h00};
    logic [15:0] tab [8] = '{16'h2264, 16'h2432, 16'h250c, 16'h2a02, 16'h2b8c, 16'h2c55, 16'h2dca, 16'h30b5};
    logic [7:0] adr [23] = '{8'h11, 8'h12, 8'h15, 8'h16, 8'h17, 8'h18, 8'h1a, 8'h1c, 8'h21, 8'h22, 8'h24,
        8'h25, 8'h26, 8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h40};
    logic [7:0] sel [6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h03, 8'h00};
    always #50 clk = ~clk;
    // Data wire has a pull-up: idle high when nobody drives
    assign wire_d = doe ? dout : (moe ? mdrv : 1'b1);
    rsv_master m (.o_link_clk(lclk), .o_sdio_drv(mdrv), .o_sdio_oe(moe), .i_sdio_out(dout), .i_sdio_oe(doe));
    rsv_regs dut (.i_clk(clk), .i_rst_n(rst_n), .i_link_clk(lclk), .i_sdio_in(wire_d), .o_sdio_out(dout),
        .o_sdio_oe(doe), .o_alert_out(aout), .o_alert_oe(aoe), .i_telem(tel), .o_hot_alarm_output(hot),
        .o_regulator_ready_output(rdy), .o_voltage_target(tgt));
    // ==========
    // Checking and verdict
    task check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task test_done;
        if (errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done
    // ==========
    // Reference model
    function logic [7:0] volt;
        return tel.sense_pos - tel.sense_neg;
    endfunction : volt
    function logic [7:0] exp_rd(input logic [7:0] a);
        logic [15:0] p;
        logic [7:0] z;
        p = volt() * tel.current;
        for (int k = 0; k < 8; k++) z[k] = int'(tel.temp) + 3 * (7 - k) >= int'(mdl[8'h22]);
        case (a)
            8'h11: return tel.status;
            8'h12: return z;
            8'h15: return tel.current;
            8'h16: return volt();
            8'h17: return tel.temp;
            8'h18: return p[15:8];
            8'h1a: return tel.vin;
            8'h21: return lim0;
            8'h26: return boot0;
            default: return mdl[a];
        endcase
    endfunction : exp_rd
    function logic [7:0] exp_tgt;
        int t;
        t = int'(mdl[8'h31]) + int'($signed(mdl[8'h33]));
        if (started == 0) return boot0;
        return (t < 0) ? 8'h00 : (t > 255) ? 8'hff : 8'(t);
    endfunction : exp_tgt
    function logic [7:0] exp_wr(input logic [7:0] a, input logic [7:0] d);
        case (a)
            8'h22, 8'h30, 8'h33: mdl[a] = d;
            8'h34: begin
                mdl[a] = d;
                if (d[1]) lock = 1;
            end
            8'h2a: begin
                if (d > 8'h08 || !$onehot(d)) return 8'h02;
                mdl[a] = d;
                mdl[8'h25] = 8'h19 / d;
            end
            8'h31: begin
                if (d > mdl[8'h30]) return 8'h01;
                if (lock != 0) return 8'h02;
                mdl[a] = d;
                started = 1;
            end
            8'h32: begin
                if (d != 8'h00 && lock != 0) return 8'h02;
                if (d == 8'h00) lock = 0;
                mdl[a] = d;
            end
            default: ;
        endcase
        return 8'h00;
    endfunction : exp_wr
    // ==========
    // Stimulus
    task new_tel;
        rsv_telem_t t;
        t = rsv_telem_t'({$random(seed), $random(seed)});
        t.temp[7] = 1'b0;
        t.sense_pos[7] = 1'b1;
        t.sense_neg[7] = 1'b0;
        tel = t;
    endtask : new_tel
    task post;
        repeat (5) @(negedge clk);
        check(tgt, exp_tgt());
        check({7'h00, hot}, {7'h00, tel.temp >= mdl[8'h22]});
        check({7'h00, aoe}, {7'h00, tel.status != mdl[8'h1c]});
        check({7'h00, aout}, 8'h00);
    endtask : post
    task wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] e;
        e = exp_wr(a, d);
        m.frame(1'b1, a, d, ans);
        check(ans, e);
        post();
    endtask : wr
    task rd(input logic [7:0] a);
        m.frame(1'b0, a, 8'h00, ans);
        check(ans, exp_rd(a));
        if (a == 8'h11) mdl[8'h1c] = tel.status;
        post();
    endtask : rd
    initial begin
        #1_000_000;
        errors++;
        test_done();
    end
    initial begin
        new_tel();
        lim0 = tel.cur_limit;
        boot0 = tel.boot;
        foreach (tab[i]) mdl[tab[i][15:8]] = tab[i][7:0];
        // Link clock keeps running through reset so the link side sees it
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        repeat (10) @(negedge clk);
        @(negedge lclk) m.run = 1'b0;
        post();
        foreach (adr[i]) rd(adr[i]);
        @(negedge clk);
        new_tel();
        repeat (6) @(negedge clk);
        foreach (adr[i]) begin
            wr(adr[i], 8'($random(seed)));
            rd(adr[i]);
        end
        wr(8'h32, 8'h00);
        wr(8'h34, 8'h00);
        wr(8'h30, 8'hb5);
        wr(8'h33, 8'h00);
        foreach (sel[i]) begin
            wr(8'h2a, sel[i]);
            rd(8'h25);
        end
        wr(8'h31, 8'hb6);
        wr(8'h31, 8'hb5);
        wr(8'h33, 8'h7f);
        wr(8'h33, 8'hff);
        wr(8'h31, 8'h40);
        wr(8'h33, 8'h80);
        wr(8'h30, 8'h50);
        wr(8'h31, 8'h51);
        wr(8'h34, 8'h02);
        wr(8'h31, 8'h10);
        wr(8'h32, 8'h03);
        wr(8'h34, 8'h00);
        wr(8'h31, 8'h10);
        rd(8'h31);
        wr(8'h32, 8'h00);
        wr(8'h31, 8'h10);
        wr(8'h32, 8'h03);
        rd(8'h32);
        wr(8'h33, 8'h00);
        wr(8'h34, 8'h01);
        wr(8'h31, 8'h00);
        check({7'h00, rdy}, 8'h01);
        wr(8'h34, 8'h00);
        wr(8'h31, 8'h05);
        check({7'h00, rdy}, 8'h01);
        wr(8'h31, 8'h00);
        check({7'h00, rdy}, 8'h00);
        wr(8'h22, tel.temp);
        rd(8'h12);
        wr(8'h22, tel.temp + 8'h01);
        rd(8'h12);
        @(negedge clk);
        new_tel();
        repeat (6) @(negedge clk);
        post();
        rd(8'h11);
        rd(8'h1c);
        test_done();
    end
endmodule : test_rsv_regs
